// ### axis_tilt.sv
// One axis of the tilt detector: outer set threshold with inner clear threshold.
`timescale 1ns/100ps
`default_nettype none
module axis_tilt
  import motion_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] accel_i,
  input  wire logic        [15:0] inner_i,
  input  wire logic        [15:0] outer_i,
  output logic                    upper_o,
  output logic                    lower_o
);
  logic        upper_reg;
  logic        upper_next;
  logic        lower_reg;
  logic        lower_next;
  logic [16:0] magnitude;
  logic [16:0] clear_level;

  always_comb begin
    magnitude   = accel_i[15] ? 17'(-$signed({accel_i[15], accel_i})) : {1'b0, accel_i};
    // Inner above outer collapses the hysteresis band onto the outer level.
    clear_level = (inner_i > outer_i) ? {1'b0, outer_i} : {1'b0, inner_i};
    upper_next  = upper_reg;
    lower_next  = lower_reg;
    if (sample_valid_i) begin
      if (!accel_i[15] && magnitude > {1'b0, outer_i}) begin
        upper_next = 1'b1;
        lower_next = 1'b0;
      end else if (accel_i[15] && magnitude > {1'b0, outer_i}) begin
        lower_next = 1'b1;
        upper_next = 1'b0;
      end else if (magnitude < clear_level) begin
        upper_next = 1'b0;
        lower_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      upper_reg <= 1'b0;
      lower_reg <= 1'b0;
    end else begin
      upper_reg <= upper_next;
      lower_reg <= lower_next;
    end
  end

  assign upper_o = upper_reg;
  assign lower_o = lower_reg;
endmodule
`default_nettype wire

// ### motion_assertions.sv
// Port checker for the motion threshold and tilt detector.
`timescale 1ns/100ps
`default_nettype none
module motion_checker
  import motion_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       sample_valid_i,
  input wire logic [5:0] wake_event_enable_i,
  input wire logic       and_or_combine_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       wake_interrupt_o,
  input wire logic       tilt_interrupt_o,
  input wire logic [7:0] tilt_source_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the tilt configuration, so latch mode can be judged from the ports.
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  assign cfg_next = (reg_write_i && reg_addr_i == TILT_CONFIG_ADDR) ? reg_wdata_i : cfg_reg;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_reg <= REG_RESET_VALUE;
    end else begin
      cfg_reg <= cfg_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_source_top_zero: assert property (tilt_source_o[7] == 1'b0)
    else $error("tilt source bit 7 set");
  a_read_source: assert property (reg_read_i && reg_addr_i == TILT_SOURCE_ADDR
    |=> reg_rdata_o == $past(tilt_source_o)) else $error("source read mismatch");
  a_ack_reads_zero: assert property (reg_read_i && reg_addr_i == TILT_ACKNOWLEDGE_ADDR
    |=> reg_rdata_o == 8'h00) else $error("acknowledge read not zero");
  // A sample taken one edge earlier may legally re-raise the interrupt.
  a_ack_clears: assert property (reg_read_i && reg_addr_i == TILT_ACKNOWLEDGE_ADDR
    && !$past(sample_valid_i) |=> !tilt_interrupt_o && !tilt_source_o[6])
    else $error("acknowledge did not clear");
  a_wake_on_sample: assert property ($changed(wake_interrupt_o)
    |-> $past(sample_valid_i)) else $error("wake changed without sample");
  a_and_empty: assert property (sample_valid_i && and_or_combine_i
    && wake_event_enable_i == 6'h00 |=> !wake_interrupt_o) else $error("empty AND fired");
  a_tilt_from_sample: assert property ($rose(tilt_interrupt_o)
    |-> $past(sample_valid_i, 2)) else $error("tilt interrupt without sample");
  a_pulse_unlatched: assert property (!cfg_reg[LATCH_REQUEST_BIT] && tilt_interrupt_o
    && !$past(sample_valid_i) |=> !tilt_interrupt_o) else $error("unlatched pulse too long");
endmodule
bind motion_threshold_direction_detect motion_checker chk (.clock_i, .reset_n_i,
  .sample_valid_i, .wake_event_enable_i, .and_or_combine_i, .reg_write_i, .reg_read_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .wake_interrupt_o, .tilt_interrupt_o,
  .tilt_source_o);
`default_nettype wire

// ### motion_host_model.sv
// Host controller model driving the register strobe port.
`timescale 1ns/100ps
`default_nettype none
module motion_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_write_o,
  output logic            reg_read_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o
);
  initial begin
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released lines show the inverse so a stale value is never mistaken for live data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge clock_i);
    reg_write_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clock_i);
    reg_read_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ### motion_pkg.sv
// Package holding register offsets, field positions and reset values of the motion detector.
package motion_pkg;
  localparam logic [7:0] WAKE_THRESHOLD_LOW_ADDR   = 8'h34;
  localparam logic [7:0] WAKE_THRESHOLD_HIGH_ADDR  = 8'h35;
  localparam logic [7:0] EVENT_MIN_DURATION_ADDR   = 8'h36;
  localparam logic [7:0] TILT_CONFIG_ADDR          = 8'h38;
  localparam logic [7:0] TILT_SOURCE_ADDR          = 8'h39;
  localparam logic [7:0] TILT_ACKNOWLEDGE_ADDR     = 8'h3A;
  localparam logic [7:0] TILT_INNER_LOW_ADDR       = 8'h3C;
  localparam logic [7:0] TILT_INNER_HIGH_ADDR      = 8'h3D;
  localparam logic [7:0] TILT_OUTER_LOW_ADDR       = 8'h3E;
  localparam logic [7:0] TILT_OUTER_HIGH_ADDR      = 8'h3F;
  localparam logic [7:0]  REG_RESET_VALUE          = 8'h00;
  localparam logic [15:0] FULL_SCALE_CODE          = 16'h7FFF;
  localparam int CHANGE_INTERRUPT_ENABLE_BIT       = 7;
  localparam int LATCH_REQUEST_BIT                 = 6;
  localparam int EVENT_ACTIVE_BIT                  = 6;
  localparam int AXIS_COUNT                        = 3;
endpackage

// ### motion_threshold_direction_detect.sv
// Free-fall/wake-up duration filter and tilt direction detector with register file.
// Operation
// - Wake threshold is 16-bit unsigned: high byte 35h, low byte 34h.
// - Threshold code 7FFFh equals full scale of the selected range.
// - Minimum duration at 36h, reset 00h, counts output samples.
// - Events shorter than the minimum duration are suppressed.
// - Duration zero raises the wake interrupt on the first qualifying sample.
// - Tilt config 38h: change enable b7, latch b6, axis enables b5..b0.
// - With change enable, tilt flag change requests a tilt interrupt.
// - With latch, tilt status is captured on change and held until acknowledge.
// - Reading 3Ah refreshes tilt source and clears tilt interrupt.
// - Upper condition: acceleration above outer threshold, positive direction.
// - Lower condition: acceleration beyond outer threshold, negative direction.
// - Set upper flag above +outer, lower flag below -outer.
// - Clear both axis flags once magnitude drops below inner threshold.
// - Inner threshold 16-bit: high byte 3Dh, low byte 3Ch.
// - Outer threshold 16-bit: high byte 3Fh, low byte 3Eh.
// - Inner above outer means no hysteresis; outer alone is used.
// - Tilt source 39h: active b6, flags b5..b0, b7 zero.
// - Wake upper: magnitude above threshold; wake lower: magnitude below it.
// - Combine select picks OR (wake-up) or AND (free-fall) of enabled events.
`timescale 1ns/100ps
`default_nettype none
module motion_threshold_direction_detect
  import motion_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] accel_x_i,
  input  wire logic [15:0] accel_y_i,
  input  wire logic [15:0] accel_z_i,
  input  wire logic [5:0]  wake_event_enable_i,
  input  wire logic        and_or_combine_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             wake_interrupt_o,
  output logic             tilt_interrupt_o,
  output logic      [7:0]  tilt_source_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Thresholds are written one byte at a time, so between the two writes of a pair the
  // comparators see a mix of old and new bytes; write both bytes before enabling events.
  logic [7:0]  wake_threshold_low_reg;
  logic [7:0]  wake_threshold_low_next;
  logic [7:0]  wake_threshold_high_reg;
  logic [7:0]  wake_threshold_high_next;
  logic [7:0]  event_min_duration_reg;
  logic [7:0]  event_min_duration_next;
  logic [7:0]  tilt_config_reg;
  logic [7:0]  tilt_config_next;
  logic [7:0]  tilt_inner_low_reg;
  logic [7:0]  tilt_inner_low_next;
  logic [7:0]  tilt_inner_high_reg;
  logic [7:0]  tilt_inner_high_next;
  logic [7:0]  tilt_outer_low_reg;
  logic [7:0]  tilt_outer_low_next;
  logic [7:0]  tilt_outer_high_reg;
  logic [7:0]  tilt_outer_high_next;

  always_comb begin
    wake_threshold_low_next  = wake_threshold_low_reg;
    wake_threshold_high_next = wake_threshold_high_reg;
    event_min_duration_next  = event_min_duration_reg;
    tilt_config_next         = tilt_config_reg;
    tilt_inner_low_next      = tilt_inner_low_reg;
    tilt_inner_high_next     = tilt_inner_high_reg;
    tilt_outer_low_next      = tilt_outer_low_reg;
    tilt_outer_high_next     = tilt_outer_high_reg;
    // A write and a read in one cycle both act; the read returns the value before the write.
    if (reg_write_i) begin
      case (reg_addr_i)
        WAKE_THRESHOLD_LOW_ADDR:  wake_threshold_low_next  = reg_wdata_i;
        WAKE_THRESHOLD_HIGH_ADDR: wake_threshold_high_next = reg_wdata_i;
        EVENT_MIN_DURATION_ADDR:  event_min_duration_next  = reg_wdata_i;
        TILT_CONFIG_ADDR:         tilt_config_next         = reg_wdata_i;
        TILT_INNER_LOW_ADDR:      tilt_inner_low_next      = reg_wdata_i;
        TILT_INNER_HIGH_ADDR:     tilt_inner_high_next     = reg_wdata_i;
        TILT_OUTER_LOW_ADDR:      tilt_outer_low_next      = reg_wdata_i;
        TILT_OUTER_HIGH_ADDR:     tilt_outer_high_next     = reg_wdata_i;
        // Source and acknowledge addresses take no write data.
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_threshold_low_reg  <= REG_RESET_VALUE;
      wake_threshold_high_reg <= REG_RESET_VALUE;
      event_min_duration_reg  <= REG_RESET_VALUE;
      tilt_config_reg         <= REG_RESET_VALUE;
      tilt_inner_low_reg      <= REG_RESET_VALUE;
      tilt_inner_high_reg     <= REG_RESET_VALUE;
      tilt_outer_low_reg      <= REG_RESET_VALUE;
      tilt_outer_high_reg     <= REG_RESET_VALUE;
    end else begin
      wake_threshold_low_reg  <= wake_threshold_low_next;
      wake_threshold_high_reg <= wake_threshold_high_next;
      event_min_duration_reg  <= event_min_duration_next;
      tilt_config_reg         <= tilt_config_next;
      tilt_inner_low_reg      <= tilt_inner_low_next;
      tilt_inner_high_reg     <= tilt_inner_high_next;
      tilt_outer_low_reg      <= tilt_outer_low_next;
      tilt_outer_high_reg     <= tilt_outer_high_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds are raw codes; FULL_SCALE_CODE maps to the selected range, so no scaling here.
  logic [15:0] wake_threshold_bits;
  logic [15:0] inner_threshold;
  logic [15:0] outer_threshold;
  assign wake_threshold_bits = {wake_threshold_high_reg, wake_threshold_low_reg};
  assign inner_threshold     = {tilt_inner_high_reg, tilt_inner_low_reg};
  assign outer_threshold     = {tilt_outer_high_reg, tilt_outer_low_reg};

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] accel [AXIS_COUNT];
  logic [16:0] axis_magnitude [AXIS_COUNT];
  logic [5:0]  axis_events;
  logic [5:0]  wake_events;
  logic        wake_condition;

  assign accel[0] = accel_x_i;
  assign accel[1] = accel_y_i;
  assign accel[2] = accel_z_i;

  // One comparator pair per axis: bit 2g+1 is the upper event, bit 2g the lower one.
  for (genvar g = 0; g < AXIS_COUNT; g++) begin : gen_wake
    // The extra magnitude bit keeps the most negative code exact instead of wrapping back to the negative code 8000h.
    assign axis_magnitude[g]  = accel[g][15] ? 17'(-$signed({accel[g][15], accel[g]}))
                                             : {1'b0, accel[g]};
    assign axis_events[2*g+1] = axis_magnitude[g] > {1'b0, wake_threshold_bits};
    assign axis_events[2*g]   = axis_magnitude[g] < {1'b0, wake_threshold_bits};
  end

  always_comb begin
    wake_events = axis_events & wake_event_enable_i;
    if (and_or_combine_i) begin
      // An AND over no enabled axis would be true by default, so it is held off instead.
      wake_condition = (wake_event_enable_i != 6'h00)
                       && (wake_events == wake_event_enable_i);
    end else begin
      wake_condition = |wake_events;
    end
  end

  // The counter saturates so a long event cannot wrap and drop the interrupt.
  // A new minimum duration applies from the next sample; the run in progress is not restarted.
  logic [7:0] duration_count_reg;
  logic [7:0] duration_count_next;
  logic       wake_interrupt_reg;
  logic       wake_interrupt_next;

  always_comb begin
    duration_count_next = duration_count_reg;
    wake_interrupt_next = wake_interrupt_reg;
    if (sample_valid_i) begin
      if (!wake_condition) begin
        duration_count_next = 8'h00;
        wake_interrupt_next = 1'b0;
      end else begin
        if (duration_count_reg != 8'hFF) begin
          duration_count_next = duration_count_reg + 8'h01;
        end
        // Count includes this sample; zero duration fires at once.
        wake_interrupt_next = (duration_count_next >= event_min_duration_reg);
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      duration_count_reg <= 8'h00;
      wake_interrupt_reg <= 1'b0;
    end else begin
      duration_count_reg <= duration_count_next;
      wake_interrupt_reg <= wake_interrupt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each axis keeps its own hysteresis state; its flags move only with a sample.
  logic [5:0] tilt_flags;

  for (genvar g = 0; g < AXIS_COUNT; g++) begin : gen_axis
    axis_tilt u_axis (
      .clock_i        (clock_i),
      .reset_n_i      (reset_n_i),
      .sample_valid_i (sample_valid_i),
      .accel_i        (accel[g]),
      .inner_i        (inner_threshold),
      .outer_i        (outer_threshold),
      .upper_o        (tilt_flags[2*g+1]),
      .lower_o        (tilt_flags[2*g])
    );
  end

  // Flags are compared only in the cycle after a sample, so a mask write alone never reports
  // a tilt change; the previous flags keep every axis so a newly enabled one compares right.
  logic       flags_fresh_reg;
  logic       flags_fresh_next;
  logic [5:0] prev_flags_reg;
  logic [5:0] prev_flags_next;
  logic [7:0] tilt_source_reg;
  logic [7:0] tilt_source_next;
  logic       tilt_interrupt_reg;
  logic       tilt_interrupt_next;
  logic       tilt_change;
  logic       ack_read;
  logic [5:0] changed_flags;

  always_comb begin
    flags_fresh_next    = sample_valid_i;
    changed_flags       = (tilt_flags ^ prev_flags_reg) & tilt_config_reg[5:0];
    tilt_change         = flags_fresh_reg && (changed_flags != 6'h00);
    ack_read            = reg_read_i && (reg_addr_i == TILT_ACKNOWLEDGE_ADDR);
    prev_flags_next     = flags_fresh_reg ? tilt_flags : prev_flags_reg;
    tilt_source_next    = tilt_source_reg;
    tilt_interrupt_next = tilt_interrupt_reg;
    // Without the latch the source simply follows the flags every cycle.
    if (!tilt_config_reg[LATCH_REQUEST_BIT]) begin
      tilt_source_next[5:0] = tilt_flags;
    end
    if (ack_read) begin
      tilt_source_next    = {2'b00, tilt_flags};
      tilt_interrupt_next = 1'b0;
    end
    // A change in the acknowledge cycle wins over the clear.
    if (tilt_change) begin
      tilt_source_next[5:0] = tilt_flags;
      tilt_source_next[EVENT_ACTIVE_BIT] = 1'b1;
      if (tilt_config_reg[CHANGE_INTERRUPT_ENABLE_BIT]) begin
        tilt_interrupt_next = 1'b1;
      end
    end else if (!tilt_config_reg[LATCH_REQUEST_BIT] && !ack_read) begin
      tilt_source_next[EVENT_ACTIVE_BIT] = 1'b0;
      tilt_interrupt_next = 1'b0;
    end
    tilt_source_next[7] = 1'b0;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_fresh_reg    <= 1'b0;
      prev_flags_reg     <= 6'h00;
      tilt_source_reg    <= REG_RESET_VALUE;
      tilt_interrupt_reg <= 1'b0;
    end else begin
      flags_fresh_reg    <= flags_fresh_next;
      prev_flags_reg     <= prev_flags_next;
      tilt_source_reg    <= tilt_source_next;
      tilt_interrupt_reg <= tilt_interrupt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered and held until the next read, so the host may take it late.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_read_i) begin
      case (reg_addr_i)
        WAKE_THRESHOLD_LOW_ADDR:  rdata_next = wake_threshold_low_reg;
        WAKE_THRESHOLD_HIGH_ADDR: rdata_next = wake_threshold_high_reg;
        EVENT_MIN_DURATION_ADDR:  rdata_next = event_min_duration_reg;
        TILT_CONFIG_ADDR:         rdata_next = tilt_config_reg;
        TILT_SOURCE_ADDR:         rdata_next = tilt_source_reg;
        TILT_INNER_LOW_ADDR:      rdata_next = tilt_inner_low_reg;
        TILT_INNER_HIGH_ADDR:     rdata_next = tilt_inner_high_reg;
        TILT_OUTER_LOW_ADDR:      rdata_next = tilt_outer_low_reg;
        TILT_OUTER_HIGH_ADDR:     rdata_next = tilt_outer_high_reg;
        default:                  rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Every output is a register, so the host never sees decode glitches.
  assign reg_rdata_o      = rdata_reg;
  assign wake_interrupt_o = wake_interrupt_reg;
  assign tilt_interrupt_o = tilt_interrupt_reg;
  assign tilt_source_o    = tilt_source_reg;
endmodule
`default_nettype wire

// ### motion_threshold_direction_detect_tb_top.sv
// Self-checking testbench of the motion threshold and tilt detector.
`timescale 1ns/100ps
`default_nettype none
module motion_threshold_direction_detect_tb_top import motion_pkg::*;;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        sample_valid_i = 1'b0;
  logic [15:0] accel_x_i = 16'h0000;
  logic [15:0] accel_y_i = 16'h0000;
  logic [15:0] accel_z_i = 16'h0000;
  logic [5:0]  wake_event_enable_i = 6'h00;
  logic        and_or_combine_i = 1'b0;
  logic        reg_write_i;
  logic        reg_read_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        wake_interrupt_o;
  logic        tilt_interrupt_o;
  logic [7:0]  tilt_source_o;
  int          err_total = 0;
  int          cmp_count = 0;
  always #4 clock_i = ~clock_i;
  motion_threshold_direction_detect uut (.clock_i, .reset_n_i, .sample_valid_i, .accel_x_i,
    .accel_y_i, .accel_z_i, .wake_event_enable_i, .and_or_combine_i, .reg_write_i,
    .reg_read_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .wake_interrupt_o,
    .tilt_interrupt_o, .tilt_source_o);
  motion_host_model host (.clock_i, .reg_rdata_i(reg_rdata_o), .reg_write_o(reg_write_i),
    .reg_read_o(reg_read_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  // Three edges after the strobe both the wake and the tilt answers have settled.
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [5:0] en,
                     input logic ao);
    @(posedge clock_i);
    accel_x_i <= x;
    accel_y_i <= y;
    wake_event_enable_i <= en;
    and_or_combine_i <= ao;
    sample_valid_i <= 1'b1;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] a [11] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3C, 8'h3D,
                           8'h3E, 8'h3F};
    foreach (a[i]) rchk(a[i], 8'h00);
    chk(wake_interrupt_o, 1'b0);
    chk(tilt_interrupt_o, 1'b0);
    chk(tilt_source_o, 8'h00);
  endtask
  task automatic t_regs();
    logic [7:0] a [7] = '{8'h34, 8'h35, 8'h36, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
    foreach (a[i]) host.wr(a[i], a[i] ^ 8'hA5);
    foreach (a[i]) rchk(a[i], a[i] ^ 8'hA5);
    host.wr(TILT_ACKNOWLEDGE_ADDR, 8'hFF);
    host.wr(TILT_SOURCE_ADDR, 8'hFF);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    rchk(TILT_SOURCE_ADDR, 8'h00);
  endtask
  task automatic t_wake();
    host.wr(WAKE_THRESHOLD_HIGH_ADDR, 8'h10);
    host.wr(WAKE_THRESHOLD_LOW_ADDR, 8'h00);
    host.wr(EVENT_MIN_DURATION_ADDR, 8'h00);
    smp(16'h2000, 16'h0000, 6'h02, 1'b0);
    chk(wake_interrupt_o, 1'b1);
    smp(16'h1000, 16'h0000, 6'h02, 1'b0);
    chk(wake_interrupt_o, 1'b0);
    host.wr(WAKE_THRESHOLD_HIGH_ADDR, FULL_SCALE_CODE[15:8]);
    host.wr(WAKE_THRESHOLD_LOW_ADDR, FULL_SCALE_CODE[7:0]);
    smp(16'h7FFF, 16'h0000, 6'h02, 1'b0);
    chk(wake_interrupt_o, 1'b0);
    host.wr(WAKE_THRESHOLD_HIGH_ADDR, 8'h10);
    host.wr(WAKE_THRESHOLD_LOW_ADDR, 8'h00);
    host.wr(EVENT_MIN_DURATION_ADDR, 8'h03);
    for (int i = 0; i < 6; i++) begin
      smp((i == 2) ? 16'h0000 : 16'h2000, 16'h0000, 6'h02, 1'b0);
      chk(wake_interrupt_o, i == 5);
    end
    host.wr(EVENT_MIN_DURATION_ADDR, 8'h00);
    smp(16'hF800, 16'h0000, 6'h01, 1'b0);
    chk(wake_interrupt_o, 1'b1);
    smp(16'hE000, 16'h0000, 6'h01, 1'b0);
    chk(wake_interrupt_o, 1'b0);
    smp(16'h2000, 16'h0000, 6'h0A, 1'b1);
    chk(wake_interrupt_o, 1'b0);
    smp(16'h2000, 16'h2000, 6'h0A, 1'b1);
    chk(wake_interrupt_o, 1'b1);
    smp(16'h2000, 16'h2000, 6'h00, 1'b1);
    chk(wake_interrupt_o, 1'b0);
  endtask
  // Each step: one sample, then the expected interrupt level and source byte.
  task automatic tilt_step(input logic [15:0] x, input logic irq, input logic [7:0] src);
    smp(x, 16'h0000, 6'h00, 1'b0);
    chk(tilt_interrupt_o, irq);
    chk(tilt_source_o, src);
  endtask
  task automatic t_tilt();
    host.wr(TILT_INNER_HIGH_ADDR, 8'h10);
    host.wr(TILT_INNER_LOW_ADDR, 8'h00);
    host.wr(TILT_OUTER_HIGH_ADDR, 8'h20);
    host.wr(TILT_OUTER_LOW_ADDR, 8'h00);
    host.wr(TILT_CONFIG_ADDR, 8'hC3);
    tilt_step(16'h3000, 1'b1, 8'h42);
    rchk(TILT_SOURCE_ADDR, 8'h42);
    tilt_step(16'h1800, 1'b1, 8'h42);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    chk(tilt_interrupt_o, 1'b0);
    chk(tilt_source_o, 8'h02);
    tilt_step(16'h0800, 1'b1, 8'h40);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    tilt_step(16'hD000, 1'b1, 8'h41);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    tilt_step(16'h0000, 1'b1, 8'h40);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    host.wr(TILT_INNER_HIGH_ADDR, 8'h30);
    tilt_step(16'h2800, 1'b1, 8'h42);
    rchk(TILT_ACKNOWLEDGE_ADDR, 8'h00);
    // A magnitude equal to the outer level is below the inner one: it must not clear.
    tilt_step(16'h2000, 1'b0, 8'h02);
    host.wr(TILT_CONFIG_ADDR, 8'h83);
    tilt_step(16'h0000, 1'b0, 8'h00);
    host.wr(TILT_CONFIG_ADDR, 8'h03);
    tilt_step(16'h3000, 1'b0, 8'h02);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_wake();
    t_tilt();
    end_of_test();
  end
endmodule
`default_nettype wire
